// [rtl/ppf_port_mux.sv]
// Pin functions of port 1 bits 2 and 5 and port 2 bits 2 to 5.
// Assumes synchronous pin inputs and an external resolver of pin levels.
//
// Overview of operation
// - Port 1 bit 2 output is open-drain only, never driven high.
// - Port 1 bit 2 carries timer zero count input or open-drain overflow.
// - Port 1 bit 5 is input only, with no output driver.
// - Low reset pin resets ports and peripherals; fetch restarts at zero.
// - Reset pin active during power-on, otherwise only when configured.
// - Reset pin activity during power-on enters in-system programming.
// - Reset puts every port 2 pin input-only, pull-up off, latch high.
// - Each port 2 pin holds its own output mode.
// - Port 2 bit 2 is MOSI: output as master, input as slave.
// - Port 2 bit 3 is MISO: input as master, output as slave.
`timescale 1ns/1ns
`default_nettype none
module ppf_port_mux
  import ppf_pkg::*;
#(
  parameter int P2_WIDTH = PPF_P2_WIDTH,
  parameter int ISP_PULSES = PPF_ISP_PULSES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  // Port 1 bit 2
  input wire logic port1_bit2_pin_in,
  output logic port1_bit2_pin_out,
  output logic port1_bit2_pin_oe,
  input wire logic p1_latch_wr,
  input wire logic p1_latch_wdata,
  input wire logic p1_bit2_od_en,
  output logic p1_bit2_level,
  // Timer zero alternate function
  input wire logic timer_zero_out_en,
  input wire logic timer_zero_ovf_level,
  output logic timer_zero_ext_pin,
  // Port 1 bit 5, reset function
  input wire logic port1_bit5_pin_in,
  output logic p1_bit5_level,
  input wire logic por_seq_active,
  input wire logic user_config_byte_one_rst_en,
  input wire logic osc_above_12mhz,
  output logic rst_fn_active,
  output logic periph_rst_req,
  output logic fetch_restart,
  output logic [15:0] fetch_addr,
  output logic isp_mode,
  output logic cfg_fast_osc_fault,
  // Port 2 pins
  input wire logic port2_bit2_pin_in,
  output logic port2_bit2_pin_out,
  output logic port2_bit2_pin_oe,
  output logic port2_bit2_pin_pu,
  input wire logic port2_bit3_pin_in,
  output logic port2_bit3_pin_out,
  output logic port2_bit3_pin_oe,
  output logic port2_bit3_pin_pu,
  input wire logic port2_bit4_pin_in,
  output logic port2_bit4_pin_out,
  output logic port2_bit4_pin_oe,
  output logic port2_bit4_pin_pu,
  input wire logic port2_bit5_pin_in,
  output logic port2_bit5_pin_out,
  output logic port2_bit5_pin_oe,
  output logic port2_bit5_pin_pu,
  // Port 2 latch and mode writes
  input wire logic p2_latch_wr,
  input wire logic [P2_WIDTH-1:0] p2_latch_wdata,
  input wire logic p2_mode_wr,
  input wire logic [1:0] p2_mode_sel,
  input wire ppf_mode_t p2_mode_wdata,
  output logic [P2_WIDTH-1:0] p2_level,
  // SPI unit side
  input wire ppf_spi_ctl_t spi_ctl,
  output ppf_spi_in_t spi_in
);

  logic ext_rst;
  logic [P2_WIDTH-1:0] p2_pin_in;

  assign p2_pin_in = {port2_bit5_pin_in, port2_bit4_pin_in,
                      port2_bit3_pin_in, port2_bit2_pin_in};

  ppf_rst_pin #(
    .ISP_PULSES(ISP_PULSES)
  ) u_rst_pin (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .rst_pin_level(port1_bit5_pin_in),
    .por_seq_active(por_seq_active),
    .ucfg_rst_sel(user_config_byte_one_rst_en),
    .rst_fn_active(rst_fn_active),
    .ext_rst_req(ext_rst),
    .isp_mode(isp_mode),
    .fetch_restart(fetch_restart)
  );

  // Port 1 bit 2 and bit 5 state
  logic p1_latch_reg, p1_latch_next;
  ppf_drive_t p1_drive_reg, p1_drive_next;
  logic p1_lvl_reg, p1_lvl_next;
  logic p15_lvl_reg, p15_lvl_next;
  logic t0_cnt_reg, t0_cnt_next;
  logic p1_value;

  always_comb begin
    p1_latch_next = p1_latch_reg;
    if (p1_latch_wr) begin
      p1_latch_next = p1_latch_wdata;
    end
    // Overflow output takes the pin from the latch
    p1_value = timer_zero_out_en ? timer_zero_ovf_level : p1_latch_reg;
    p1_drive_next = PPF_DRIVE_OFF;
    if (p1_bit2_od_en || timer_zero_out_en) begin
      // Only ever pulls low; high comes from outside
      p1_drive_next = ppf_drive(PPF_MODE_OPEN_DRAIN, p1_value);
    end
    p1_lvl_next = port1_bit2_pin_in;
    // Count input reads the pin, so a low latch masks it when p1_bit2_od_en is set and the overflow output is off
    t0_cnt_next = port1_bit2_pin_in;
    p15_lvl_next = port1_bit5_pin_in;
    // Pin reset has the last word over writes and the timer
    if (ext_rst) begin
      p1_latch_next = PPF_LATCH_RST;
      p1_drive_next = PPF_DRIVE_OFF;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      p1_latch_reg <= PPF_LATCH_RST;
      p1_drive_reg <= PPF_DRIVE_OFF;
      p1_lvl_reg <= 1'b0;
      t0_cnt_reg <= 1'b0;
      p15_lvl_reg <= 1'b0;
    end else begin
      p1_latch_reg <= p1_latch_next;
      p1_drive_reg <= p1_drive_next;
      p1_lvl_reg <= p1_lvl_next;
      t0_cnt_reg <= t0_cnt_next;
      p15_lvl_reg <= p15_lvl_next;
    end
  end

  // Open-drain pin: data line held low, enable does the pulling
  assign port1_bit2_pin_out = 1'b0;
  assign port1_bit2_pin_oe = p1_drive_reg.oe;
  assign p1_bit2_level = p1_lvl_reg;
  assign timer_zero_ext_pin = t0_cnt_reg;
  assign p1_bit5_level = p15_lvl_reg;

  // Reset pin control outputs
  logic fault_reg, fault_next;
  logic [15:0] fetch_addr_reg, fetch_addr_next;

  always_comb begin
    // Flags a configuration the external side must not choose
    fault_next = osc_above_12mhz & ~user_config_byte_one_rst_en;
    // No vector input exists, so every restart fetches from zero
    fetch_addr_next = fetch_addr_reg;
    if (ext_rst) begin
      fetch_addr_next = PPF_RESET_VECTOR;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fault_reg <= 1'b0;
      fetch_addr_reg <= PPF_RESET_VECTOR;
    end else begin
      fault_reg <= fault_next;
      fetch_addr_reg <= fetch_addr_next;
    end
  end

  assign periph_rst_req = ext_rst;
  assign fetch_addr = fetch_addr_reg;
  assign cfg_fast_osc_fault = fault_reg;

  // Port 2 state, one mode register per pin
  logic [P2_WIDTH-1:0] p2_latch_reg, p2_latch_next;
  ppf_mode_t p2_mode_reg [P2_WIDTH];
  ppf_mode_t p2_mode_next [P2_WIDTH];
  ppf_drive_t p2_drive_reg [P2_WIDTH];
  ppf_drive_t p2_drive_next [P2_WIDTH];
  ppf_drive_t p2_plain [P2_WIDTH];
  ppf_drive_t p2_alt [P2_WIDTH];
  logic [P2_WIDTH-1:0] p2_alt_on;
  logic [P2_WIDTH-1:0] p2_lvl_reg, p2_lvl_next;
  ppf_spi_in_t spi_in_reg, spi_in_next;

  // Alternate-function drive of each port 2 pin
  always_comb begin
    for (int k = 0; k < P2_WIDTH; k++) begin
      p2_alt[k] = PPF_DRIVE_OFF;
      p2_alt_on[k] = 1'b0;
    end
    // Enabling the SPI unit claims all four port 2 pins at once
    if (spi_ctl.enable) begin
      p2_alt_on[PPF_P2_MOSI] = 1'b1;
      p2_alt_on[PPF_P2_MISO] = 1'b1;
      p2_alt_on[PPF_P2_SS] = 1'b1;
      p2_alt_on[PPF_P2_SCK] = 1'b1;
      if (spi_ctl.master) begin
        p2_alt[PPF_P2_MOSI] = ppf_drive(PPF_MODE_PUSH_PULL, spi_ctl.mosi_out);
        p2_alt[PPF_P2_SCK] = ppf_drive(PPF_MODE_PUSH_PULL, spi_ctl.sck_out);
      end else begin
        p2_alt[PPF_P2_MISO] = ppf_drive(PPF_MODE_PUSH_PULL, spi_ctl.miso_out);
      end
      // Slave select always stays an input
      p2_alt[PPF_P2_SS] = PPF_DRIVE_OFF;
    end
  end

  genvar i;
  generate
    for (i = 0; i < P2_WIDTH; i++) begin : g_p2
      always_comb begin
        p2_mode_next[i] = p2_mode_reg[i];
        if (p2_mode_wr && (p2_mode_sel == 2'(i))) begin
          p2_mode_next[i] = p2_mode_wdata;
        end
        p2_plain[i] = ppf_drive(p2_mode_reg[i], p2_latch_reg[i]);
        p2_drive_next[i] = p2_alt_on[i] ? p2_alt[i] : p2_plain[i];
        // Pin reset wins over a mode write in the same cycle
        if (ext_rst) begin
          p2_mode_next[i] = PPF_MODE_RST;
          p2_drive_next[i] = PPF_DRIVE_OFF;
        end
      end

      always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
          p2_mode_reg[i] <= PPF_MODE_RST;
          p2_drive_reg[i] <= PPF_DRIVE_OFF;
        end else begin
          p2_mode_reg[i] <= p2_mode_next[i];
          p2_drive_reg[i] <= p2_drive_next[i];
        end
      end
    end
  endgenerate

  always_comb begin
    p2_latch_next = p2_latch_reg;
    if (p2_latch_wr) begin
      p2_latch_next = p2_latch_wdata;
    end
    if (ext_rst) begin
      p2_latch_next = {P2_WIDTH{PPF_LATCH_RST}};
    end
    p2_lvl_next = p2_pin_in;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      p2_latch_reg <= {P2_WIDTH{PPF_LATCH_RST}};
      p2_lvl_reg <= '0;
    end else begin
      p2_latch_reg <= p2_latch_next;
      p2_lvl_reg <= p2_lvl_next;
    end
  end

  // SPI unit inputs, read from the pins whatever drives them
  always_comb begin
    spi_in_next.mosi_in = p2_pin_in[PPF_P2_MOSI];
    spi_in_next.miso_in = p2_pin_in[PPF_P2_MISO];
    // Deselected unless the unit is an enabled slave
    spi_in_next.ss_n_in = (spi_ctl.enable && !spi_ctl.master) ?
                          p2_pin_in[PPF_P2_SS] : 1'b1;
    spi_in_next.sck_in = p2_pin_in[PPF_P2_SCK];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_in_reg <= '{mosi_in: 1'b0, miso_in: 1'b0, ss_n_in: 1'b1, sck_in: 1'b0};
    end else begin
      spi_in_reg <= spi_in_next;
    end
  end

  assign p2_level = p2_lvl_reg;
  assign spi_in = spi_in_reg;

  // Pin drives come straight from flip-flops, so no glitches reach the pads
  assign port2_bit2_pin_out = p2_drive_reg[PPF_P2_MOSI].out;
  assign port2_bit2_pin_oe = p2_drive_reg[PPF_P2_MOSI].oe;
  assign port2_bit2_pin_pu = p2_drive_reg[PPF_P2_MOSI].pu;
  assign port2_bit3_pin_out = p2_drive_reg[PPF_P2_MISO].out;
  assign port2_bit3_pin_oe = p2_drive_reg[PPF_P2_MISO].oe;
  assign port2_bit3_pin_pu = p2_drive_reg[PPF_P2_MISO].pu;
  assign port2_bit4_pin_out = p2_drive_reg[PPF_P2_SS].out;
  assign port2_bit4_pin_oe = p2_drive_reg[PPF_P2_SS].oe;
  assign port2_bit4_pin_pu = p2_drive_reg[PPF_P2_SS].pu;
  assign port2_bit5_pin_out = p2_drive_reg[PPF_P2_SCK].out;
  assign port2_bit5_pin_oe = p2_drive_reg[PPF_P2_SCK].oe;
  assign port2_bit5_pin_pu = p2_drive_reg[PPF_P2_SCK].pu;

endmodule
`default_nettype wire

// [rtl/ppf_pkg.sv]
// Constants, modes and carrier types for the port 1 / port 2 pin mux.
// Assumes one core clock and an active-low asynchronous reset.
package ppf_pkg;

  localparam int PPF_P2_WIDTH = 4;
  // Port 2 vector index of each pin (bit 2 .. bit 5)
  localparam int PPF_P2_MOSI = 0;
  localparam int PPF_P2_MISO = 1;
  localparam int PPF_P2_SS = 2;
  localparam int PPF_P2_SCK = 3;

  typedef enum logic [1:0] {
    PPF_MODE_QUASI,
    PPF_MODE_PUSH_PULL,
    PPF_MODE_INPUT_ONLY,
    PPF_MODE_OPEN_DRAIN
  } ppf_mode_t;

  localparam ppf_mode_t PPF_MODE_RST = PPF_MODE_INPUT_ONLY;
  localparam logic PPF_LATCH_RST = 1'b1;
  localparam logic [15:0] PPF_RESET_VECTOR = 16'h0000;
  localparam int PPF_ISP_PULSES = 3;

  typedef struct packed {
    logic out;
    logic oe;
    logic pu;
  } ppf_drive_t;

  localparam ppf_drive_t PPF_DRIVE_OFF = '{out: 1'b0, oe: 1'b0, pu: 1'b0};

  typedef struct packed {
    logic enable;
    logic master;
    logic mosi_out;
    logic miso_out;
    logic sck_out;
  } ppf_spi_ctl_t;

  typedef struct packed {
    logic mosi_in;
    logic miso_in;
    logic ss_n_in;
    logic sck_in;
  } ppf_spi_in_t;

  // Pin drive for a plain port bit in a given output mode
  function automatic ppf_drive_t ppf_drive(ppf_mode_t mode, logic value);
    ppf_drive_t d;
    d = PPF_DRIVE_OFF;
    case (mode)
      PPF_MODE_QUASI: begin
        d.oe = ~value;
        d.pu = 1'b1;
      end
      PPF_MODE_PUSH_PULL: begin
        d.oe = 1'b1;
        d.out = value;
      end
      PPF_MODE_OPEN_DRAIN: begin
        d.oe = ~value;
      end
      default: d = PPF_DRIVE_OFF;
    endcase
    return d;
  endfunction

endpackage

// [rtl/ppf_rst_pin.sv]
// Reset-pin function of port 1 bit 5: reset request, restart, ISP entry.
// Assumes por_seq_active comes from the power-on circuit, synchronous.
`timescale 1ns/1ns
`default_nettype none
module ppf_rst_pin
  import ppf_pkg::*;
#(
  parameter int ISP_PULSES = PPF_ISP_PULSES
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic rst_pin_level,
  input wire logic por_seq_active,
  input wire logic ucfg_rst_sel,
  output logic rst_fn_active,
  output logic ext_rst_req,
  output logic isp_mode,
  output logic fetch_restart
);

  localparam int CW = $clog2(ISP_PULSES + 1);
  localparam logic [CW-1:0] CNT_LAST = CW'(ISP_PULSES - 1);

  logic pin_d_reg, pin_d_next;
  logic ext_rst_reg, ext_rst_next;
  logic isp_reg, isp_next;
  logic restart_reg, restart_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic fn_active;

  assign fn_active = por_seq_active | ucfg_rst_sel;

  always_comb begin
    pin_d_next = rst_pin_level;
    ext_rst_next = fn_active & ~rst_pin_level;
    restart_next = ext_rst_reg & ~ext_rst_next;
    isp_next = isp_reg;
    cnt_next = cnt_reg;
    // Released pulses on the pin during power-on select ISP
    if (!por_seq_active) begin
      cnt_next = '0;
    end else if (rst_pin_level && !pin_d_reg && !isp_reg) begin
      if (cnt_reg == CNT_LAST) begin
        isp_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + CW'(1);
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_d_reg <= 1'b1;
      ext_rst_reg <= 1'b0;
      isp_reg <= 1'b0;
      restart_reg <= 1'b0;
      cnt_reg <= '0;
    end else begin
      pin_d_reg <= pin_d_next;
      ext_rst_reg <= ext_rst_next;
      isp_reg <= isp_next;
      restart_reg <= restart_next;
      cnt_reg <= cnt_next;
    end
  end

  assign rst_fn_active = fn_active;
  assign ext_rst_req = ext_rst_reg;
  assign isp_mode = isp_reg;
  assign fetch_restart = restart_reg;

endmodule
`default_nettype wire

// [tb/ppf_peer.sv]
// Far side: reset circuit on port 1 bit 5 and an SPI peer on port 2.
// Assumes the bench passes the device drives in and takes pin levels out.
`timescale 1ns/1ns
`default_nettype none
module ppf_peer (
  input wire logic core_clk,
  input wire logic rst_hold,
  input wire logic peer_on,
  input wire logic peer_master,
  input wire logic [3:0] peer_val,
  input wire logic [3:0] dev_oe,
  input wire logic [3:0] dev_out,
  input wire logic [3:0] dev_pu,
  output logic rst_pin,
  output logic [3:0] p2_pin
);
  logic [3:0] peer_oe;
  logic [3:0] float_reg = 4'h5;
  // Reset line has a pull-up, so released reads high
  assign rst_pin = ~rst_hold;
  // Peer master drives MOSI, SS, SCK; peer slave only MISO
  assign peer_oe = !peer_on ? 4'h0 : peer_master ? 4'hD : 4'h2;
  // Undriven lines without pull-up toggle so a stale level never passes
  always_ff @(posedge core_clk) begin
    float_reg <= ~float_reg;
  end
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      p2_pin[i] = dev_oe[i] ? dev_out[i] : peer_oe[i] ? peer_val[i] :
                  dev_pu[i] ? 1'b1 : float_reg[i];
    end
  end
endmodule
`default_nettype wire

// [tb/ppf_port_mux_props.sv]
// Checker for the pin mux, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ns
`default_nettype none
module ppf_port_mux_props
  import ppf_pkg::*;
(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic port1_bit2_pin_out,
  input wire logic port1_bit5_pin_in,
  input wire logic por_seq_active,
  input wire logic user_config_byte_one_rst_en,
  input wire logic osc_above_12mhz,
  input wire logic rst_fn_active,
  input wire logic periph_rst_req,
  input wire logic fetch_restart,
  input wire logic [15:0] fetch_addr,
  input wire logic isp_mode,
  input wire logic cfg_fast_osc_fault,
  input wire logic port2_bit2_pin_oe,
  input wire logic port2_bit3_pin_oe,
  input wire logic port2_bit4_pin_oe,
  input wire logic port2_bit5_pin_oe,
  input wire logic port2_bit4_pin_in,
  input wire ppf_spi_ctl_t spi_ctl,
  input wire ppf_spi_in_t spi_in
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!arst_n);
  chk_od_never_high: assert property (port1_bit2_pin_out == 1'b0)
    else $error("port 1 bit 2 driven high");
  chk_rst_fn_sel: assert property
    (rst_fn_active == (por_seq_active | user_config_byte_one_rst_en))
    else $error("reset function select wrong");
  chk_rst_req_lag: assert property
    (periph_rst_req == $past(rst_fn_active & ~port1_bit5_pin_in))
    else $error("reset request wrong");
  chk_rst_drive_off: assert property (periph_rst_req [*2] |=>
    !(port2_bit2_pin_oe | port2_bit3_pin_oe | port2_bit4_pin_oe | port2_bit5_pin_oe))
    else $error("port 2 driven in reset");
  chk_restart_pulse: assert property ($fell(periph_rst_req) |-> ##[0:1] fetch_restart)
    else $error("no restart after reset");
  chk_restart_addr: assert property
    (fetch_restart |-> fetch_addr == 16'h0000 ##1 !fetch_restart)
    else $error("restart address or width wrong");
  chk_isp_sticky: assert property (isp_mode |=> isp_mode)
    else $error("programming mode dropped");
  chk_isp_in_por: assert property ($rose(isp_mode) |-> $past(por_seq_active))
    else $error("programming mode outside power-on");
  chk_osc_fault: assert property
    (cfg_fast_osc_fault == $past(osc_above_12mhz & ~user_config_byte_one_rst_en))
    else $error("fast oscillator flag wrong");
  chk_spi_master_dir: assert property
    (spi_ctl.enable && spi_ctl.master && !periph_rst_req
    |=> port2_bit2_pin_oe && !port2_bit3_pin_oe && spi_in.ss_n_in)
    else $error("master pin directions wrong");
  chk_spi_slave_dir: assert property
    (spi_ctl.enable && !spi_ctl.master && !periph_rst_req
    |=> !port2_bit2_pin_oe && port2_bit3_pin_oe && !port2_bit4_pin_oe)
    else $error("slave pin directions wrong");
  chk_ss_follow: assert property
    (spi_ctl.enable && !spi_ctl.master |=> spi_in.ss_n_in == $past(port2_bit4_pin_in))
    else $error("slave select not passed");
  cov_isp: cover property ($rose(isp_mode));
  cov_pin_reset: cover property ($fell(periph_rst_req));
  cov_slave: cover property (spi_ctl.enable && !spi_ctl.master);
  cov_master: cover property (spi_ctl.enable && spi_ctl.master);
endmodule
bind ppf_port_mux ppf_port_mux_props i_ppf_port_mux_props (.*);
`default_nettype wire

// [tb/tb.sv]
// Self-checking bench for the pin mux with a reset circuit and SPI peer.
// Assumes the package and the design top compile before this file.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp=%0h got=%0h", n, e, g); end end
module tb;
  import ppf_pkg::*;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic port1_bit2_pin_in, port1_bit2_pin_out, port1_bit2_pin_oe, p1_bit2_level;
  logic p1_latch_wr = 1'b0, p1_latch_wdata = 1'b1, p1_bit2_od_en = 1'b0;
  logic timer_zero_out_en = 1'b0, timer_zero_ovf_level = 1'b0, timer_zero_ext_pin;
  logic port1_bit5_pin_in, p1_bit5_level, por_seq_active = 1'b0;
  logic user_config_byte_one_rst_en = 1'b0, osc_above_12mhz = 1'b0;
  logic rst_fn_active, periph_rst_req, fetch_restart, isp_mode, cfg_fast_osc_fault;
  logic [15:0] fetch_addr;
  logic port2_bit2_pin_in, port2_bit3_pin_in, port2_bit4_pin_in, port2_bit5_pin_in;
  logic port2_bit2_pin_out, port2_bit3_pin_out, port2_bit4_pin_out, port2_bit5_pin_out;
  logic port2_bit2_pin_oe, port2_bit3_pin_oe, port2_bit4_pin_oe, port2_bit5_pin_oe;
  logic port2_bit2_pin_pu, port2_bit3_pin_pu, port2_bit4_pin_pu, port2_bit5_pin_pu;
  logic p2_latch_wr = 1'b0, p2_mode_wr = 1'b0;
  logic [3:0] p2_latch_wdata = 4'hF, p2_level;
  logic [1:0] p2_mode_sel = 2'h0;
  ppf_mode_t p2_mode_wdata = PPF_MODE_INPUT_ONLY;
  ppf_spi_ctl_t spi_ctl = '0;
  ppf_spi_in_t spi_in;
  logic t0_src = 1'b1, rst_hold = 1'b0, peer_on = 1'b0, peer_master = 1'b0;
  logic [3:0] peer_val = 4'h0, p2_pin, p2_oe, p2_out, p2_pu;
  logic [31:0] rnd = 32'h3A9E;
  ppf_mode_t m_mode[4];
  logic [3:0] m_latch;
  int err_count = 0;
  int comparisons = 0;
  assign p2_oe = {port2_bit5_pin_oe, port2_bit4_pin_oe, port2_bit3_pin_oe, port2_bit2_pin_oe};
  assign p2_out = {port2_bit5_pin_out, port2_bit4_pin_out, port2_bit3_pin_out, port2_bit2_pin_out};
  assign p2_pu = {port2_bit5_pin_pu, port2_bit4_pin_pu, port2_bit3_pin_pu, port2_bit2_pin_pu};
  assign {port2_bit5_pin_in, port2_bit4_pin_in, port2_bit3_pin_in, port2_bit2_pin_in} = p2_pin;
  // Open-drain line with an external pull-up and source
  assign port1_bit2_pin_in = port1_bit2_pin_oe ? 1'b0 : t0_src;
  ppf_port_mux i_ppf_port_mux (.*);
  ppf_peer i_ppf_peer (.core_clk(core_clk), .rst_hold(rst_hold), .peer_on(peer_on),
    .peer_master(peer_master), .peer_val(peer_val), .dev_oe(p2_oe), .dev_out(p2_out),
    .dev_pu(p2_pu), .rst_pin(port1_bit5_pin_in), .p2_pin(p2_pin));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  function automatic logic [31:0] lfsr(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Expected {out, oe, pu} of a plain port 2 pin
  function automatic logic [2:0] exp_drv(ppf_mode_t m, logic l);
    case (m)
      PPF_MODE_QUASI: return {1'b0, ~l, 1'b1};
      PPF_MODE_PUSH_PULL: return {l, 1'b1, 1'b0};
      PPF_MODE_OPEN_DRAIN: return {1'b0, ~l, 1'b0};
      default: return 3'h0;
    endcase
  endfunction
  task complete_run;
    $display("comparisons %0d err_count %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task settle(int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask
  task model_reset;
    foreach (m_mode[i]) m_mode[i] = PPF_MODE_INPUT_ONLY;
    m_latch = 4'hF;
  endtask
  task check_p2;
    for (int i = 0; i < 4; i++) begin
      `CHK("p2_drive", exp_drv(m_mode[i], m_latch[i]), {p2_out[i], p2_oe[i], p2_pu[i]})
    end
  endtask
  task write_p2(logic [1:0] s, ppf_mode_t m, logic [3:0] l);
    @(posedge core_clk);
    p2_latch_wr <= 1'b1;
    p2_latch_wdata <= l;
    p2_mode_wr <= 1'b1;
    p2_mode_sel <= s;
    p2_mode_wdata <= m;
    @(posedge core_clk);
    p2_latch_wr <= 1'b0;
    p2_mode_wr <= 1'b0;
    m_latch = l;
    m_mode[s] = m;
    settle(2);
  endtask
  initial begin
    model_reset();
    repeat (12) @(posedge core_clk);
    arst_n <= 1'b1;
    settle(1);
    check_p2();
    `CHK("isp", 1'b0, isp_mode)
    for (int k = 0; k < 12; k++) begin
      rnd = lfsr(rnd);
      write_p2(rnd[1:0], ppf_mode_t'(rnd[3:2]), rnd[7:4]);
      check_p2();
    end
    @(posedge core_clk);
    p1_bit2_od_en <= 1'b1;
    p1_latch_wr <= 1'b1;
    p1_latch_wdata <= 1'b0;
    @(posedge core_clk);
    p1_latch_wr <= 1'b0;
    settle(2);
    `CHK("p1b2_oe", 1'b1, port1_bit2_pin_oe)
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      timer_zero_out_en <= 1'b1;
      timer_zero_ovf_level <= v[0];
      settle(2);
      `CHK("t0_oe", ~v[0], port1_bit2_pin_oe)
    end
    @(posedge core_clk);
    timer_zero_out_en <= 1'b0;
    p1_bit2_od_en <= 1'b0;
    for (int v = 0; v < 2; v++) begin
      @(posedge core_clk);
      t0_src <= v[0];
      settle(2);
      `CHK("t0_in", v[0], timer_zero_ext_pin)
      `CHK("p1b2_lvl", v[0], p1_bit2_level)
      `CHK("p1b2_off", 1'b0, port1_bit2_pin_oe)
    end
    for (int ms = 0; ms < 2; ms++) begin
      rnd = lfsr(rnd);
      @(posedge core_clk);
      spi_ctl <= '{enable: 1'b1, master: ms[0], mosi_out: rnd[0],
                   miso_out: rnd[1], sck_out: rnd[2]};
      peer_on <= 1'b1;
      peer_master <= ~ms[0];
      peer_val <= rnd[7:4];
      settle(2);
      if (ms[0]) begin
        `CHK("m_oe", 4'b1001, p2_oe)
        `CHK("m_out", {rnd[2], rnd[0]}, {p2_out[3], p2_out[0]})
        `CHK("m_in", {rnd[5], 1'b1}, {spi_in.miso_in, spi_in.ss_n_in})
      end else begin
        `CHK("s_oe", 4'b0010, p2_oe)
        `CHK("s_out", rnd[1], p2_out[1])
        `CHK("s_mosi", rnd[4], spi_in.mosi_in)
        `CHK("s_ss_sck", {rnd[6], rnd[7]}, {spi_in.ss_n_in, spi_in.sck_in})
        `CHK("p2_lvl", {rnd[7], rnd[6], rnd[1], rnd[4]}, p2_level)
      end
    end
    @(posedge core_clk);
    spi_ctl <= '0;
    peer_on <= 1'b0;
    write_p2(2'h3, PPF_MODE_PUSH_PULL, 4'h0);
    @(posedge core_clk);
    rst_hold <= 1'b1;
    osc_above_12mhz <= 1'b1;
    settle(2);
    `CHK("rst_req_off", 1'b0, periph_rst_req)
    `CHK("p1b5_lvl", 1'b0, p1_bit5_level)
    `CHK("osc_fault", 1'b1, cfg_fast_osc_fault)
    @(posedge core_clk);
    user_config_byte_one_rst_en <= 1'b1;
    settle(3);
    `CHK("rst_req", 1'b1, periph_rst_req)
    `CHK("osc_ok", 1'b0, cfg_fast_osc_fault)
    model_reset();
    check_p2();
    @(posedge core_clk);
    rst_hold <= 1'b0;
    for (int i = 0; i < 10 && fetch_restart !== 1'b1; i++) @(negedge core_clk);
    `CHK("restart", 1'b1, fetch_restart)
    if (fetch_restart !== 1'b1) complete_run();
    `CHK("fetch_addr", 16'h0000, fetch_addr)
    check_p2();
    @(posedge core_clk);
    user_config_byte_one_rst_en <= 1'b0;
    por_seq_active <= 1'b1;
    repeat (3) begin
      repeat (2) @(posedge core_clk);
      rst_hold <= 1'b1;
      repeat (2) @(posedge core_clk);
      rst_hold <= 1'b0;
    end
    for (int i = 0; i < 10 && isp_mode !== 1'b1; i++) @(negedge core_clk);
    `CHK("isp_on", 1'b1, isp_mode)
    if (isp_mode !== 1'b1) complete_run();
    @(posedge core_clk);
    por_seq_active <= 1'b0;
    settle(3);
    `CHK("isp_held", 1'b1, isp_mode)
    complete_run();
  end
endmodule
`default_nettype wire
